// ### src/ttc_consts.vh
// constants for the trb type checker and event segment table decoder
// assumes byte-addressed apb with 32-bit data, one register per aligned word
// What this block does
// - classify code by ring kind
// - transfer codes 1..8 decode in order
// - command ring takes link and 9..25
// - event rings carry only codes 32..39, plus vendor codes with vendor ok
// - reserved 0,26-31,40-47; vendor 48-63 optional
// - command error event: trb error, pointer, slot 0
// - transfer error event: trb error, pointer, slot, endpoint
// - disallowed transfer type puts endpoint in error
// - allowed types depend on endpoint type
// - allowed types depend on descriptor type
// - segment base in bits 63:6, 64-byte aligned
// - segment size 16..4096 trbs in bits 15:0
// - table found by base and size registers
// - entry is four words, 16 bytes
// - decode code together with ring kind
`ifndef TTC_CONSTS_VH
`define TTC_CONSTS_VH

// register byte offsets
`define TTC_REG_CTRL 8'h00
`define TTC_REG_STATUS 8'h04
`define TTC_REG_MASK 8'h08
`define TTC_REG_CHECK 8'h0c
`define TTC_REG_PTR_LO 8'h10
`define TTC_REG_PTR_HI 8'h14
`define TTC_REG_EVENT 8'h18
`define TTC_REG_EP_STATE 8'h1c
`define TTC_REG_TBL_BASE_LO 8'h20
`define TTC_REG_TBL_BASE_HI 8'h24
`define TTC_REG_TBL_SIZE 8'h28
`define TTC_REG_ENTRY0 8'h2c
`define TTC_REG_ENTRY1 8'h30
`define TTC_REG_ENTRY2 8'h34
`define TTC_REG_ENTRY3 8'h38
`define TTC_REG_SEG_LO 8'h3c
`define TTC_REG_SEG_HI 8'h40
`define TTC_REG_SEG_INFO 8'h44

// ring kinds
`define TTC_RING_CMD 2'h0
`define TTC_RING_EVT 2'h1
`define TTC_RING_XFER 2'h2

// endpoint / descriptor kinds
`define TTC_EP_ISOCH 3'h0
`define TTC_EP_INTR 3'h1
`define TTC_EP_CTRL 3'h2
`define TTC_EP_BULK 3'h3
`define TTC_EP_VENDOR 3'h4

// type codes
`define TTC_T_NORMAL 6'h01
`define TTC_T_SETUP 6'h02
`define TTC_T_DATA 6'h03
`define TTC_T_STATUS 6'h04
`define TTC_T_ISOCH 6'h05
`define TTC_T_LINK 6'h06
`define TTC_T_EVDATA 6'h07
`define TTC_T_NOOP 6'h08
`define TTC_T_CMD_FIRST 6'h09
`define TTC_T_CMD_LAST 6'h19
`define TTC_T_EVT_FIRST 6'h20
`define TTC_T_EVT_XFER 6'h20
`define TTC_T_EVT_CMDDONE 6'h21
`define TTC_T_EVT_LAST 6'h27
`define TTC_T_VEND_FIRST 6'h30

// error completion code
`define TTC_CC_TRB_ERROR 8'h05

// table entry layout
`define TTC_ALIGN_BITS 6
`define TTC_SEG_MIN 16'h0010
`define TTC_SEG_MAX 16'h1000

// status bits
`define TTC_ST_CMD_ERR 0
`define TTC_ST_XFER_ERR 1
`define TTC_ST_EVT_BAD 2
`define TTC_ST_SEG_BAD 3
`define TTC_ST_W 4

`endif

// ### src/ttc_type_decode.v
// combinational type-code checker: ring kind, endpoint kind, descriptor kind
// assumes codes and kinds are stable inputs from the same clock domain
`timescale 1ns/1ns
`include "ttc_consts.vh"

module ttc_type_decode (
   // request
   input wire [5:0] type_code,
   input wire [1:0] ring_kind,
   input wire [2:0] ep_kind,
   input wire [2:0] td_kind,
   input wire vendor_ok,
   // result
   output reg allowed,
   output reg reserved,
   output reg vendor
);

   always @* begin
      reserved = (type_code == 6'h00) || (type_code > `TTC_T_CMD_LAST &&
         type_code < `TTC_T_EVT_FIRST) || (type_code > `TTC_T_EVT_LAST &&
         type_code < `TTC_T_VEND_FIRST);
      vendor = type_code >= `TTC_T_VEND_FIRST;
      allowed = 1'b0;
      // codes mean different things per ring, so the ring selects the table
      case (ring_kind)
         `TTC_RING_CMD: begin
            allowed = (type_code == `TTC_T_LINK) || (type_code >= `TTC_T_CMD_FIRST &&
               type_code <= `TTC_T_CMD_LAST) || (vendor && vendor_ok);
         end
         `TTC_RING_EVT: begin
            allowed = (type_code >= `TTC_T_EVT_FIRST && type_code <= `TTC_T_EVT_LAST) ||
               (vendor && vendor_ok);
         end
         `TTC_RING_XFER: begin
            case (type_code)
               `TTC_T_NORMAL: allowed = (td_kind != `TTC_EP_VENDOR);
               `TTC_T_SETUP, `TTC_T_DATA, `TTC_T_STATUS: begin
                  allowed = (ep_kind == `TTC_EP_CTRL) && (td_kind == `TTC_EP_CTRL);
               end
               `TTC_T_ISOCH: begin
                  allowed = (ep_kind == `TTC_EP_ISOCH) && (td_kind == `TTC_EP_ISOCH);
               end
               `TTC_T_LINK: allowed = 1'b1;
               `TTC_T_EVDATA, `TTC_T_NOOP: allowed = 1'b1;
               default: allowed = vendor && vendor_ok &&
                  ((td_kind == `TTC_EP_VENDOR) || (ep_kind == `TTC_EP_VENDOR));
            endcase
         end
         default: allowed = 1'b0;
      endcase
   end

endmodule // ttc_type_decode

// ### src/ttc_seg_entry.v
// parses one 16-byte event segment table entry held as four words
// assumes words are written by software before the check is run
`timescale 1ns/1ns
`include "ttc_consts.vh"

module ttc_seg_entry (
   // entry words
   input wire [31:0] word0,
   input wire [31:0] word1,
   input wire [31:0] word2,
   input wire [31:0] word3,
   // parsed
   output wire [63:0] seg_base,
   output wire [15:0] seg_size,
   output wire base_ok,
   output wire size_ok,
   output wire rsvd_ok
);

   // low word at byte 0, high at 4, size at 8, reserved at 12
   assign seg_base = {word1, word0[31:`TTC_ALIGN_BITS], 6'h00};
   assign base_ok = (word0[`TTC_ALIGN_BITS-1:0] == 6'h00);
   assign seg_size = word2[15:0];
   assign size_ok = (seg_size >= `TTC_SEG_MIN) && (seg_size <= `TTC_SEG_MAX);
   assign rsvd_ok = (word2[31:16] == 16'h0000) && (word3 == 32'h00000000);

endmodule // ttc_seg_entry

// ### src/ttc_checker.v
// top: apb register file around the type checker and segment entry parser
// assumes a single 100 MHz clock; software plays the role of the ring fetcher
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "ttc_consts.vh"

module ttc_checker #(
   parameter TBL_MAX = 16'h00ff
) (
   // clock and reset
   input wire ref_clk,
   input wire rstn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // interrupt
   output reg irq
);

   // control: [1:0] ring, [4:2] endpoint, [7:5] descriptor, [8] vendor ok,
   // [15:9] slot on transfer rings, [20:16] endpoint id, [29:24] type code
   reg [31:0] ctrl;
   reg [3:0] status;
   reg [3:0] mask;
   reg [31:0] ptr_lo;
   reg [31:0] ptr_hi;
   reg [31:0] event_word;
   reg [31:0] ep_error;
   reg [31:0] tbl_base_lo;
   reg [31:0] tbl_base_hi;
   reg [15:0] tbl_size;
   reg [31:0] entry0;
   reg [31:0] entry1;
   reg [31:0] entry2;
   reg [31:0] entry3;
   reg [1:0] result;
   reg [2:0] state;
   reg [3:0] events;
   reg [31:0] next_rdata;
   reg next_err;

   localparam ST_IDLE = 3'h0;
   localparam ST_CHECK = 3'h1;
   localparam ST_POST = 3'h2;
   localparam ST_SEG = 3'h3;

   wire allowed;
   wire reserved;
   wire vendor;
   wire [63:0] seg_base;
   wire [15:0] seg_size;
   wire base_ok;
   wire size_ok;
   wire rsvd_ok;

   wire [5:0] code = ctrl[29:24];
   wire [1:0] ring = ctrl[1:0];
   wire [6:0] slot = ctrl[15:9];
   wire [4:0] ep_id = ctrl[20:16];
   wire wr = psel & penable & pwrite & pready;
   wire rd = psel & ~penable & ~pwrite;

   ttc_type_decode u_dec (
      .type_code(code),
      .ring_kind(ring),
      .ep_kind(ctrl[4:2]),
      .td_kind(ctrl[7:5]),
      .vendor_ok(ctrl[8]),
      .allowed(allowed),
      .reserved(reserved),
      .vendor(vendor)
   );

   ttc_seg_entry u_seg (
      .word0(entry0),
      .word1(entry1),
      .word2(entry2),
      .word3(entry3),
      .seg_base(seg_base),
      .seg_size(seg_size),
      .base_ok(base_ok),
      .size_ok(size_ok),
      .rsvd_ok(rsvd_ok)
   );

   function valid_addr;
      input [7:0] a;
      begin
         valid_addr = (a[1:0] == 2'h0) && (a <= `TTC_REG_SEG_INFO);
      end
   endfunction

   // read mux, registered at the setup cycle so prdata is a flop
   always @* begin
      next_rdata = 32'h00000000;
      next_err = ~valid_addr(paddr);
      case (paddr)
         `TTC_REG_CTRL: next_rdata = ctrl;
         `TTC_REG_STATUS: next_rdata = {28'h0000000, status};
         `TTC_REG_MASK: next_rdata = {28'h0000000, mask};
         `TTC_REG_CHECK: next_rdata = {27'h0000000, vendor, reserved, result, state == ST_IDLE};
         `TTC_REG_PTR_LO: next_rdata = ptr_lo;
         `TTC_REG_PTR_HI: next_rdata = ptr_hi;
         `TTC_REG_EVENT: next_rdata = event_word;
         `TTC_REG_EP_STATE: next_rdata = ep_error;
         `TTC_REG_TBL_BASE_LO: next_rdata = tbl_base_lo;
         `TTC_REG_TBL_BASE_HI: next_rdata = tbl_base_hi;
         `TTC_REG_TBL_SIZE: next_rdata = {16'h0000, tbl_size};
         `TTC_REG_ENTRY0: next_rdata = entry0;
         `TTC_REG_ENTRY1: next_rdata = entry1;
         `TTC_REG_ENTRY2: next_rdata = entry2;
         `TTC_REG_ENTRY3: next_rdata = entry3;
         `TTC_REG_SEG_LO: next_rdata = seg_base[31:0];
         `TTC_REG_SEG_HI: next_rdata = seg_base[63:32];
         `TTC_REG_SEG_INFO: next_rdata = {13'h0000, rsvd_ok, size_ok, base_ok, seg_size};
         default: next_rdata = 32'h00000000;
      endcase
   end

   // one wait-free access: pready is high for every access phase
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         if (psel & ~penable) begin
            pslverr <= next_err;
            prdata <= rd ? next_rdata : 32'h00000000;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // checker sequence: write ctrl bit 31 to start a type check,
   // bit 30 to parse the entry at table index held in ctrl[15:9]
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= 32'h00000000;
         mask <= 4'h0;
         ptr_lo <= 32'h00000000;
         ptr_hi <= 32'h00000000;
         event_word <= 32'h00000000;
         ep_error <= 32'h00000000;
         tbl_base_lo <= 32'h00000000;
         tbl_base_hi <= 32'h00000000;
         tbl_size <= 16'h0000;
         entry0 <= 32'h00000000;
         entry1 <= 32'h00000000;
         entry2 <= 32'h00000000;
         entry3 <= 32'h00000000;
         result <= 2'h0;
         state <= ST_IDLE;
         events <= 4'h0;
      end else begin
         events <= 4'h0;
         if (wr) begin
            case (paddr)
               `TTC_REG_CTRL: ctrl <= {2'h0, pwdata[29:0]};
               `TTC_REG_MASK: mask <= pwdata[3:0];
               `TTC_REG_PTR_LO: ptr_lo <= {pwdata[31:4], 4'h0};
               `TTC_REG_PTR_HI: ptr_hi <= pwdata;
               `TTC_REG_EP_STATE: ep_error <= ep_error & ~pwdata;
               `TTC_REG_TBL_BASE_LO: tbl_base_lo <= {pwdata[31:`TTC_ALIGN_BITS], 6'h00};
               `TTC_REG_TBL_BASE_HI: tbl_base_hi <= pwdata;
               `TTC_REG_TBL_SIZE: tbl_size <= pwdata[15:0];
               `TTC_REG_ENTRY0: entry0 <= pwdata;
               `TTC_REG_ENTRY1: entry1 <= pwdata;
               `TTC_REG_ENTRY2: entry2 <= pwdata;
               `TTC_REG_ENTRY3: entry3 <= pwdata;
               default: ;
            endcase
         end
         case (state)
            ST_IDLE: begin
               if (wr && paddr == `TTC_REG_CTRL && pwdata[31]) begin
                  state <= ST_CHECK;
               end else if (wr && paddr == `TTC_REG_CTRL && pwdata[30]) begin
                  state <= ST_SEG;
               end
            end
            ST_CHECK: begin
               result <= allowed ? 2'h1 : 2'h2;
               state <= allowed ? ST_IDLE : ST_POST;
               if (allowed && ring == `TTC_RING_EVT) begin
                  event_word <= {16'h0000, 2'h0, code, 8'h00};
               end
               if (!allowed && ring == `TTC_RING_EVT) begin
                  events[`TTC_ST_EVT_BAD] <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_POST: begin
               if (ring == `TTC_RING_CMD) begin
                  // completion word: code, event type, slot forced to zero
                  event_word <= {8'h00, 2'h0, `TTC_T_EVT_CMDDONE, `TTC_CC_TRB_ERROR, 8'h00};
                  events[`TTC_ST_CMD_ERR] <= 1'b1;
               end else begin
                  event_word <= {1'b0, slot, 3'h0, ep_id, `TTC_T_EVT_XFER,
                     `TTC_CC_TRB_ERROR, 2'h0};
                  ep_error[ep_id] <= 1'b1;
                  events[`TTC_ST_XFER_ERR] <= 1'b1;
               end
               state <= ST_IDLE;
            end
            ST_SEG: begin
               // entry address is base plus sixteen bytes per index
               ptr_lo <= tbl_base_lo + {21'h000000, slot, 4'h0};
               ptr_hi <= tbl_base_hi;
               if (!(base_ok && size_ok && rsvd_ok) || {9'h000, slot} >= tbl_size ||
                  tbl_size > TBL_MAX) begin
                  events[`TTC_ST_SEG_BAD] <= 1'b1;
               end
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // sticky status, set wins over a write-one-to-clear in the same cycle
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         status <= 4'h0;
         irq <= 1'b0;
      end else begin
         status <= (status & ~((wr && paddr == `TTC_REG_STATUS) ? pwdata[3:0] : 4'h0)) | events;
         irq <= |(((status & ~((wr && paddr == `TTC_REG_STATUS) ? pwdata[3:0] : 4'h0)) |
            events) & mask);
      end
   end

endmodule // ttc_checker

// ### dv/ttc_sva_checker.sv
// port-level assertions for the trb type checker register block
// assumes the bind below attaches it to every instance of the top module
`timescale 1ns/1ns
`include "ttc_consts.vh"

module ttc_sva #(
   parameter TBL_MAX = 16'h00ff
) (
   // clock and reset
   input wire ref_clk,
   input wire rstn,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // interrupt
   input wire irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   wire acc = psel && penable && pready;
   wire rd_ok = acc && !pwrite && !pslverr;
   wire bad = paddr > 8'h44 || paddr[1:0] != 2'b00;

   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_ready_once: assert property (pready |=> !pready)
      else $error("answer longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("answer outside access phase");
   a_err_unmapped: assert property (acc && bad |-> pslverr)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (acc && !bad |-> !pslverr)
      else $error("mapped access refused");
   a_err_zero: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   a_ctrl_start: assert property (rd_ok && paddr == `TTC_REG_CTRL |-> prdata[31:30] == 2'b00)
      else $error("start bits read back");
   a_ptr_align: assert property (rd_ok && paddr == `TTC_REG_PTR_LO |-> prdata[3:0] == 4'h0)
      else $error("pointer not on entry boundary");
   a_base_align: assert property (rd_ok && paddr == `TTC_REG_TBL_BASE_LO |-> prdata[5:0] == 6'h00)
      else $error("table base not aligned");
   a_info_size: assert property (rd_ok && paddr == `TTC_REG_SEG_INFO |->
      prdata[17] == (prdata[15:0] >= 16'h0010 && prdata[15:0] <= 16'h1000))
      else $error("segment size verdict wrong");
   a_mask_quiet: assert property (acc && pwrite && paddr == `TTC_REG_MASK && pwdata == 32'h0
      |-> ##[1:2] !irq)
      else $error("irq stays high with all masked");
endmodule // ttc_sva

bind ttc_checker ttc_sva #(.TBL_MAX(TBL_MAX)) ttc_sva_inst (.ref_clk(ref_clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// ### dv/ttc_sw_model.sv
// software side: builds one segment table entry and its buffer size
// assumes the bench copies the words into the entry registers
`timescale 1ns/1ns

module ttc_sw_model (
   // request
   input wire logic [63:0] seg_addr,
   input wire logic [15:0] seg_trbs,
   // entry
   output logic [31:0] w0,
   output logic [31:0] w1,
   output logic [31:0] w2,
   output logic [31:0] w3,
   output logic [31:0] buf_bytes
);
   assign w0 = {seg_addr[31:6], 6'h00};
   assign w1 = seg_addr[63:32];
   assign w2 = {16'h0000, seg_trbs};
   assign w3 = 32'h0;
   // sixteen bytes a trb, rounded up to whole cache lines
   assign buf_bytes = ({12'h0, seg_trbs, 4'h0} + 32'h3f) & ~32'h3f;
endmodule // ttc_sw_model

// ### dv/tb.sv
// self-checking bench for the trb type checker over apb
// assumes the software model stands in for ring memory and table entries
`timescale 1ns/1ns
`include "ttc_consts.vh"
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin err_total++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (x)); end end

module tb;
   logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, q;
   wire [31:0] prdata, w0, w1, w2, w3, buf_bytes;
   wire pready, pslverr, irq;
   logic [63:0] seg_addr = 64'h0000_0001_2345_6780;
   logic [15:0] seg_trbs = 16'h0010;
   logic [18:0] rows[$];
   logic [15:0] sz[4] = '{16'h0010, 16'h000f, 16'h1000, 16'h1001};
   int err_total = 0, num_checks = 0, i;

   ttc_checker #(.TBL_MAX(16'h00ff)) ttc_checker_inst (.ref_clk(ref_clk), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   ttc_sw_model ttc_sw_model_inst (.seg_addr(seg_addr), .seg_trbs(seg_trbs), .w0(w0),
      .w1(w1), .w2(w2), .w3(w3), .buf_bytes(buf_bytes));

   initial forever #5 ref_clk = ~ref_clk;

   task report_and_stop;
      if (err_total == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      n = 0;
      @(posedge ref_clk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin err_total++; report_and_stop(); end
         @(posedge ref_clk);
      end
      q = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] x);
      apb(0, a, 32'h0);
      `CHK(q, x)
   endtask

   // idle bit may still be low while the check runs; repeat until it reads high
   task run(input logic [31:0] c);
      int n;
      apb(1, `TTC_REG_CTRL, c);
      n = 0;
      q = 0;
      while (q[0] !== 1'b1) begin
         apb(0, `TTC_REG_CHECK, 32'h0);
         n++;
         if (n > 20) begin err_total++; report_and_stop(); end
      end
   endtask

   task irqc(input logic x);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, x)
   endtask

   // slot 3, endpoint 2, start bit
   function automatic [31:0] cw(input [18:0] r);
      cw = {2'b10, r[9:4], 3'b000, 5'd2, 7'd3, r[10], r[13:11], r[16:14], r[18:17]};
   endfunction

   initial begin
      // row: ring, endpoint kind, descriptor kind, vendor ok, code, {vendor,rsvd,result}
      for (i = 1; i < 64; i++) begin
         if (i <= 8) rows.push_back({2'h2, 3'h2, 3'h2, 1'b0, 6'(i), i == 5 ? 4'h2 : 4'h1});
         else if (i <= 25) rows.push_back({2'h0, 3'h0, 3'h0, 1'b0, 6'(i), 4'h1});
         else if (i >= 32 && i <= 39) rows.push_back({2'h1, 6'h0, 1'b0, 6'(i), 4'h1});
         else if (i >= 48) rows.push_back({2'h0, 6'h0, 1'b1, 6'(i), 4'h9});
         else rows.push_back({2'h2, 3'h3, 3'h3, 1'b0, 6'(i), 4'h6});
      end
      rows.push_back({2'h0, 6'h0, 1'b0, 6'h00, 4'h6});
      rows.push_back({2'h0, 6'h0, 1'b0, 6'h01, 4'h2});
      rows.push_back({2'h1, 6'h0, 1'b0, 6'h08, 4'h2});
      rows.push_back({2'h0, 6'h0, 1'b0, 6'h3f, 4'ha});
      rows.push_back({2'h2, 3'h3, 3'h3, 1'b0, 6'h02, 4'h2});
      rows.push_back({2'h2, 3'h1, 3'h1, 1'b0, 6'h05, 4'h2});
      rows.push_back({2'h2, 3'h0, 3'h0, 1'b0, 6'h05, 4'h1});
      rows.push_back({2'h2, 3'h2, 3'h3, 1'b0, 6'h02, 4'h2});
      rows.push_back({2'h2, 3'h4, 3'h4, 1'b1, 6'h3f, 4'h9});
      rows.push_back({2'h2, 3'h3, 3'h3, 1'b1, 6'h30, 4'ha});
      repeat (15) @(posedge ref_clk);
      `CHK({pready, pslverr, irq, prdata}, 35'h0)
      @(posedge ref_clk);
      rstn <= 1;
      rdc(`TTC_REG_STATUS, 32'h0);
      rdc(`TTC_REG_MASK, 32'h0);
      for (i = 0; i < rows.size(); i++) begin
         run(cw(rows[i]));
         `CHK(q[4:1], rows[i][3:0])
      end
      apb(1, `TTC_REG_STATUS, 32'hf);
      rdc(`TTC_REG_STATUS, 32'h0);
      run(cw({2'h0, 6'h0, 1'b0, 6'h01, 4'h0}));
      rdc(`TTC_REG_STATUS, 32'h1);
      rdc(`TTC_REG_EVENT, 32'h0021_0500);
      apb(1, `TTC_REG_PTR_LO, 32'h1234_567f);
      rdc(`TTC_REG_PTR_LO, 32'h1234_5670);
      run(cw({2'h2, 3'h3, 3'h3, 1'b0, 6'h02, 4'h0}));
      rdc(`TTC_REG_STATUS, 32'h3);
      rdc(`TTC_REG_EVENT, 32'h0302_8014);
      rdc(`TTC_REG_EP_STATE, 32'h4);
      apb(1, `TTC_REG_EP_STATE, 32'h4);
      rdc(`TTC_REG_EP_STATE, 32'h0);
      apb(1, `TTC_REG_MASK, 32'h2);
      irqc(1);
      apb(1, `TTC_REG_STATUS, 32'h2);
      irqc(0);
      apb(1, `TTC_REG_MASK, 32'h1);
      irqc(1);
      apb(1, `TTC_REG_MASK, 32'h0);
      irqc(0);
      apb(1, `TTC_REG_STATUS, 32'h1);
      rdc(`TTC_REG_STATUS, 32'h0);
      apb(1, `TTC_REG_TBL_BASE_LO, 32'h1000_003f);
      rdc(`TTC_REG_TBL_BASE_LO, 32'h1000_0000);
      apb(1, `TTC_REG_TBL_BASE_HI, 32'h0);
      apb(1, `TTC_REG_TBL_SIZE, 32'h4);
      rdc(`TTC_REG_TBL_SIZE, 32'h4);
      for (i = 0; i < 4; i++) begin
         seg_trbs <= sz[i];
         apb(1, `TTC_REG_ENTRY0, w0);
         apb(1, `TTC_REG_ENTRY1, w1);
         apb(1, `TTC_REG_ENTRY2, w2);
         apb(1, `TTC_REG_ENTRY3, w3);
         run(32'h4000_0400);
         rdc(`TTC_REG_SEG_INFO, {13'h0, 1'b1, i[0] ? 1'b0 : 1'b1, 1'b1, sz[i]});
         `CHK(buf_bytes[5:0], 6'h00)
         `CHK((buf_bytes - {12'h0, sz[i], 4'h0}) < 32'h40, 1'b1)
      end
      rdc(`TTC_REG_SEG_LO, 32'h2345_6780);
      rdc(`TTC_REG_SEG_HI, 32'h1);
      rdc(`TTC_REG_PTR_LO, 32'h1000_0020);
      // last loop pass left an out-of-range size behind; restore a legal one
      apb(1, `TTC_REG_ENTRY2, 32'h0000_0010);
      apb(1, `TTC_REG_ENTRY0, w0 | 32'h20);
      run(32'h4000_0400);
      apb(0, `TTC_REG_SEG_INFO, 32'h0);
      `CHK(q[18:16], 3'b110)
      apb(1, `TTC_REG_ENTRY0, w0);
      apb(1, `TTC_REG_ENTRY3, 32'h1);
      run(32'h4000_0400);
      apb(0, `TTC_REG_SEG_INFO, 32'h0);
      `CHK(q[18:16], 3'b011)
      apb(0, 8'h48, 32'h0);
      `CHK({e, q}, 33'h1_0000_0000)
      apb(0, 8'h02, 32'h0);
      `CHK(e, 1'b1)
      apb(0, `TTC_REG_CTRL, 32'h0);
      `CHK(q[31:30], 2'b00)
      // mid-run reset with a pending unmasked segment error and a loaded table
      apb(1, `TTC_REG_MASK, 32'h8);
      irqc(1);
      @(posedge ref_clk);
      rstn <= 0;
      repeat (2) @(posedge ref_clk);
      `CHK({pready, pslverr, irq, prdata}, 35'h0)
      rstn <= 1;
      rdc(`TTC_REG_STATUS, 32'h0);
      rdc(`TTC_REG_MASK, 32'h0);
      rdc(`TTC_REG_TBL_SIZE, 32'h0);
      run(cw({2'h0, 6'h0, 1'b0, 6'h09, 4'h0}));
      `CHK(q[4:1], 4'h1)
      report_and_stop();
   end
endmodule // tb
